// ===== src/clk_supervisor_pkg.sv
`default_nettype none
package clk_supervisor_pkg;
  localparam int NUM_DIV = 5;
  localparam int CLK_PERIOD_PS = 10000;
  // Coincidence windows in picoseconds
  localparam int LOCK_SET_WIDE_PS = 9500;
  localparam int LOCK_CLR_WIDE_PS = 15000;
  localparam int LOCK_SET_NARROW_PS = 3500;
  localparam int LOCK_CLR_NARROW_PS = 7000;
  localparam int SET_WIDE_RAW = LOCK_SET_WIDE_PS / CLK_PERIOD_PS;
  localparam int SET_NARROW_RAW = LOCK_SET_NARROW_PS / CLK_PERIOD_PS;
  localparam logic [7:0] SET_WIDE_CYC =
    8'(SET_WIDE_RAW < 1 ? 1 : SET_WIDE_RAW);
  localparam logic [7:0] SET_NARROW_CYC =
    8'(SET_NARROW_RAW < 1 ? 1 : SET_NARROW_RAW);
  localparam logic [7:0] CLR_WIDE_CYC =
    8'((LOCK_CLR_WIDE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] CLR_NARROW_CYC =
    8'((LOCK_CLR_NARROW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [4:0] ARM_CYC_0 = 5'h03;
  localparam logic [4:0] ARM_CYC_1 = 5'h06;
  localparam logic [4:0] ARM_CYC_2 = 5'h0C;
  localparam logic [4:0] ARM_CYC_3 = 5'h18;
  // Register byte offsets
  localparam logic [7:0] PLL_CTRL_ADDR = 8'h00;
  localparam logic [7:0] LOCK_CTRL_ADDR = 8'h04;
  localparam logic [7:0] REFMON_CTRL_ADDR = 8'h08;
  localparam logic [7:0] FUNC_CTRL_ADDR = 8'h0C;
  localparam logic [7:0] CLK_SEL_ADDR = 8'h10;
  localparam logic [7:0] STATUS_ADDR = 8'h14;
  localparam logic [7:0] DIV_CFG_ADDR = 8'h20;
  localparam logic [7:0] DIV_PHASE_ADDR = 8'h40;
  // Field positions
  localparam int STAT_SEL_LSB = 2;
  localparam int WINDOW_BIT = 5;
  localparam int LD_DIS_BIT = 6;
  localparam int MON_EN_BIT = 2;
  localparam int ARM_SEL_LSB = 5;
  localparam int ROLE_LSB = 5;
  // Reset values
  localparam logic [1:0] ANTIBL_RST = 2'h0;
  localparam logic [3:0] STAT_SEL_RST = 4'h0;
  localparam logic [1:0] ARM_SEL_RST = 2'h0;
  localparam logic [1:0] ROLE_RST = 2'h0;
  localparam logic CLK_SEL_RST = 1'b1;
  localparam logic [15:0] REF_LOSS_TICKS_DEF = 16'h0040;
  // Status select codes
  localparam logic [3:0] SEL_LOCK_HI = 4'h3;
  localparam logic [3:0] SEL_LOCK_LO = 4'hB;
  localparam logic [3:0] SEL_ALD_PCH = 4'hC;
  localparam logic [3:0] SEL_ALD_NCH = 4'h5;
  localparam logic [3:0] SEL_REFERENCE_LOST_FLAG_HI = 4'hA;
  localparam logic [3:0] SEL_REFERENCE_LOST_FLAG_LO = 4'hF;
  localparam logic [3:0] SEL_OR_HI = 4'hD;
  localparam logic [3:0] SEL_OR_LO = 4'hE;
  typedef enum logic [1:0] {
    ROLE_CLEAR = 2'h0, ROLE_ALIGN = 2'h1, ROLE_RSVD = 2'h2, ROLE_PDOWN = 2'h3
  } role_type;
  typedef struct packed {
    logic nosync;
    logic pdown;
    logic bypass;
    logic [3:0] low_cycles;
    logic [3:0] high_cycles;
  } div_cfg_type;
  typedef struct packed {
    logic start_level;
    logic [3:0] phase;
  } div_phase_type;
  localparam div_cfg_type DIV_CFG_RST = '0;
  localparam div_phase_type DIV_PHASE_RST = '0;
endpackage
`default_nettype wire

// ===== src/clk_supervisor.sv
`default_nettype none
module clk_supervisor
  import clk_supervisor_pkg::*;
#(
  parameter logic [15:0] REF_LOSS_TICKS = REF_LOSS_TICKS_DEF
) (
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire logic REF_CLK_I,
  input wire logic FB_CLK_I,
  input wire logic VCO_CLK_I,
  input wire logic DIST_CLK_I,
  input wire logic FUNC_PIN_I,
  input wire logic ANALOG_LOCK_I,
  output logic STATUS_O,
  output logic STATUS_OE_O,
  output logic CP_TRISTATE_O,
  output logic POWERDOWN_O,
  output logic [1:0] ANTIBACKLASH_O,
  output logic DIST_SEL_O,
  output logic [NUM_DIV-1:0] DIV_OUT_O,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I
);
  // Pin synchronisers: ref, fb, vco, dist, func, analog lock
  logic [5:0] s1_ff, s2_ff, s3_ff, filt_ff, prev_ff;
  logic [5:0] pins, rise;
  assign pins = {ANALOG_LOCK_I, FUNC_PIN_I, DIST_CLK_I, VCO_CLK_I,
                 FB_CLK_I, REF_CLK_I};
  always_ff @(posedge CLK_SYS_I) begin
    s1_ff <= pins;
    s2_ff <= s1_ff;
    s3_ff <= s2_ff;
  end
  // Agreement of stages two and three filters single-cycle glitches
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      filt_ff <= 6'h10;
      prev_ff <= 6'h10;
    end else begin
      filt_ff <= (s2_ff & s3_ff) | (filt_ff & (s2_ff | s3_ff));
      prev_ff <= filt_ff;
    end
  end
  assign rise = filt_ff & ~prev_ff;
  logic ref_edge, fb_edge, vco_tick, func_lvl;
  assign ref_edge = rise[0];
  assign fb_edge = rise[1];
  assign vco_tick = rise[2];
  assign func_lvl = filt_ff[4];

  // Control registers
  logic [1:0] antibl_ff;
  logic [3:0] stat_sel_ff;
  logic window_ff, ld_dis_ff, mon_en_ff, clk_sel_ff;
  logic [1:0] arm_sel_ff;
  role_type role_ff;
  div_cfg_type div_cfg_ff [NUM_DIV];
  div_phase_type div_phase_ff [NUM_DIV];
  logic hard_clear_n, pdown_n;
  // Raw pin so the clear acts with no clock running
  assign hard_clear_n = FUNC_PIN_I | (role_ff != ROLE_CLEAR);
  assign pdown_n = FUNC_PIN_I | (role_ff != ROLE_PDOWN);

  // AXI4-Lite slave
  logic aw_full_ff, w_full_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic wr_do, wr_hit;
  logic [31:0] wr_val;
  assign wr_do = aw_full_ff & w_full_ff & ~S_AXI_BVALID_O;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wr_val[b*8 +: 8] = w_strb_ff[b] ? w_data_ff[b*8 +: 8] : 8'h00;
    end
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      aw_full_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      S_AXI_AWREADY_O <= 1'b0;
    end else begin
      S_AXI_AWREADY_O <= ~aw_full_ff & ~S_AXI_AWREADY_O;
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_full_ff <= 1'b1;
        aw_addr_ff <= S_AXI_AWADDR_I;
      end else if (wr_do) begin
        aw_full_ff <= 1'b0;
      end
    end
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      w_full_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      S_AXI_WREADY_O <= 1'b0;
    end else begin
      S_AXI_WREADY_O <= ~w_full_ff & ~S_AXI_WREADY_O;
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_full_ff <= 1'b1;
        w_data_ff <= S_AXI_WDATA_I;
        w_strb_ff <= S_AXI_WSTRB_I;
      end else if (wr_do) begin
        w_full_ff <= 1'b0;
      end
    end
  end
  always_comb begin
    wr_hit = (aw_addr_ff[1:0] == 2'h0) && (aw_addr_ff <= STATUS_ADDR - 8'h4
      || (aw_addr_ff >= DIV_CFG_ADDR && aw_addr_ff < DIV_CFG_ADDR + 8'h14)
      || (aw_addr_ff >= DIV_PHASE_ADDR && aw_addr_ff < DIV_PHASE_ADDR + 8'h14));
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= 2'h0;
    end else if (wr_do) begin
      S_AXI_BVALID_O <= 1'b1;
      S_AXI_BRESP_O <= wr_hit ? 2'h0 : 2'h2;
    end else if (S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  // Registers cleared by the function pin in its clear role
  always_ff @(posedge CLK_SYS_I or negedge hard_clear_n) begin
    if (!hard_clear_n) begin
      antibl_ff <= ANTIBL_RST;
      stat_sel_ff <= STAT_SEL_RST;
      window_ff <= 1'b0;
      ld_dis_ff <= 1'b0;
    end else if (!RESET_N_I) begin
      antibl_ff <= ANTIBL_RST;
      stat_sel_ff <= STAT_SEL_RST;
      window_ff <= 1'b0;
      ld_dis_ff <= 1'b0;
    end else if (wr_do && aw_addr_ff == PLL_CTRL_ADDR) begin
      stat_sel_ff <= wr_val[STAT_SEL_LSB +: 4];
    end else if (wr_do && aw_addr_ff == LOCK_CTRL_ADDR) begin
      antibl_ff <= wr_val[1:0];
      window_ff <= wr_val[WINDOW_BIT];
      ld_dis_ff <= wr_val[LD_DIS_BIT];
    end
  end
  always_ff @(posedge CLK_SYS_I or negedge hard_clear_n) begin
    if (!hard_clear_n) begin
      mon_en_ff <= 1'b0;
      arm_sel_ff <= ARM_SEL_RST;
      role_ff <= role_type'(ROLE_RST);
      clk_sel_ff <= CLK_SEL_RST;
    end else if (!RESET_N_I) begin
      mon_en_ff <= 1'b0;
      arm_sel_ff <= ARM_SEL_RST;
      role_ff <= role_type'(ROLE_RST);
      clk_sel_ff <= CLK_SEL_RST;
    end else if (wr_do && aw_addr_ff == REFMON_CTRL_ADDR) begin
      mon_en_ff <= wr_val[MON_EN_BIT];
      arm_sel_ff <= wr_val[ARM_SEL_LSB +: 2];
    end else if (wr_do && aw_addr_ff == FUNC_CTRL_ADDR) begin
      role_ff <= role_type'(wr_val[ROLE_LSB +: 2]);
    end else if (wr_do && aw_addr_ff == CLK_SEL_ADDR) begin
      clk_sel_ff <= wr_val[0];
    end
  end
  generate
    for (genvar d = 0; d < NUM_DIV; d++) begin : g_reg
      always_ff @(posedge CLK_SYS_I or negedge hard_clear_n) begin
        if (!hard_clear_n) begin
          div_cfg_ff[d] <= DIV_CFG_RST;
          div_phase_ff[d] <= DIV_PHASE_RST;
        end else if (!RESET_N_I) begin
          div_cfg_ff[d] <= DIV_CFG_RST;
          div_phase_ff[d] <= DIV_PHASE_RST;
        end else if (wr_do && aw_addr_ff == DIV_CFG_ADDR + 8'(4 * d)) begin
          div_cfg_ff[d] <= wr_val[10:0];
        end else if (wr_do && aw_addr_ff == DIV_PHASE_ADDR + 8'(4 * d)) begin
          div_phase_ff[d] <= wr_val[4:0];
        end
      end
    end
  endgenerate

  // Digital lock detector: pairs one reference and one feedback edge
  logic lock_ff;
  logic [1:0] pend_ff;
  logic [7:0] gap_ff;
  logic [7:0] set_cyc, clr_cyc;
  assign set_cyc = window_ff ? SET_NARROW_CYC : SET_WIDE_CYC;
  assign clr_cyc = window_ff ? CLR_NARROW_CYC : CLR_WIDE_CYC;
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I || ld_dis_ff) begin
      lock_ff <= 1'b0;
      pend_ff <= 2'h0;
      gap_ff <= 8'h00;
    end else if (ref_edge && fb_edge) begin
      lock_ff <= 1'b1;
      pend_ff <= 2'h0;
    end else if (pend_ff == 2'h0) begin
      pend_ff <= {fb_edge, ref_edge};
      gap_ff <= 8'h00;
    end else if ((pend_ff[0] && fb_edge) || (pend_ff[1] && ref_edge)) begin
      pend_ff <= 2'h0;
      if (gap_ff < set_cyc) begin
        lock_ff <= 1'b1;
      end else if (gap_ff >= clr_cyc - 8'h01) begin
        lock_ff <= 1'b0;
      end
    end else begin
      // Same-side edge again or partner overdue
      if (ref_edge || fb_edge) begin
        pend_ff <= {fb_edge, ref_edge};
        gap_ff <= 8'h00;
        lock_ff <= 1'b0;
      end else begin
        if (gap_ff != 8'hFF) begin
          gap_ff <= gap_ff + 8'h1;
        end
        if (gap_ff >= clr_cyc - 8'h01) begin
          lock_ff <= 1'b0;
        end
      end
    end
  end

  // Reference monitor, armed after lock has held for enough PFD cycles
  logic [4:0] lock_run_ff, arm_need;
  logic [15:0] vco_cnt_ff;
  logic ref_lost_ff, armed;
  always_comb begin
    unique case (arm_sel_ff)
      2'h0: arm_need = ARM_CYC_0;
      2'h1: arm_need = ARM_CYC_1;
      2'h2: arm_need = ARM_CYC_2;
      2'h3: arm_need = ARM_CYC_3;
    endcase
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I || !lock_ff) begin
      lock_run_ff <= 5'h00;
    end else if (ref_edge && lock_run_ff != ARM_CYC_3) begin
      lock_run_ff <= lock_run_ff + 5'h01;
    end
  end
  // Sticky once armed: lock may fall with the reference it watches
  logic armed_ff;
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I || !mon_en_ff) begin
      armed_ff <= 1'b0;
    end else if (lock_run_ff >= arm_need) begin
      armed_ff <= 1'b1;
    end
  end
  assign armed = armed_ff;
  // Counts only on VCO edges: no VCO, no detection
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I || ref_edge || !armed) begin
      vco_cnt_ff <= 16'h0000;
    end else if (vco_tick && vco_cnt_ff != REF_LOSS_TICKS) begin
      vco_cnt_ff <= vco_cnt_ff + 16'h0001;
    end
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I || !mon_en_ff) begin
      ref_lost_ff <= 1'b0;
    end else if (armed && vco_cnt_ff == REF_LOSS_TICKS) begin
      ref_lost_ff <= 1'b1;
    end
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      CP_TRISTATE_O <= 1'b0;
    end else begin
      CP_TRISTATE_O <= ref_lost_ff && mon_en_ff;
    end
  end

  // Status pin multiplexer
  logic unlock_or_lost;
  assign unlock_or_lost = ~lock_ff | ref_lost_ff;
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      STATUS_O <= 1'b0;
      STATUS_OE_O <= 1'b1;
    end else begin
      STATUS_OE_O <= 1'b1;
      STATUS_O <= 1'b0;
      case (stat_sel_ff)
        SEL_LOCK_HI: STATUS_O <= lock_ff;
        SEL_LOCK_LO: STATUS_O <= ~lock_ff;
        SEL_ALD_PCH: begin
          STATUS_O <= 1'b1;
          STATUS_OE_O <= filt_ff[5];
        end
        SEL_ALD_NCH: begin
          STATUS_O <= 1'b0;
          STATUS_OE_O <= filt_ff[5];
        end
        SEL_REFERENCE_LOST_FLAG_HI: STATUS_O <= ref_lost_ff;
        SEL_REFERENCE_LOST_FLAG_LO: STATUS_O <= ~ref_lost_ff;
        SEL_OR_HI: STATUS_O <= unlock_or_lost;
        SEL_OR_LO: STATUS_O <= ~unlock_or_lost;
        default: STATUS_O <= 1'b0;
      endcase
    end
  end

  // Power-down held asynchronously; registers untouched so settings return
  always_ff @(posedge CLK_SYS_I or negedge pdown_n) begin
    if (!pdown_n) begin
      POWERDOWN_O <= 1'b1;
    end else if (!RESET_N_I) begin
      POWERDOWN_O <= 1'b0;
    end else begin
      POWERDOWN_O <= 1'b0;
    end
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      ANTIBACKLASH_O <= ANTIBL_RST;
      DIST_SEL_O <= CLK_SEL_RST;
    end else begin
      ANTIBACKLASH_O <= antibl_ff;
      DIST_SEL_O <= clk_sel_ff;
    end
  end

  // Output dividers on the selected fast clock
  logic fast_lvl, fast_tick, align_hold, align_rise;
  assign fast_lvl = clk_sel_ff ? filt_ff[3] : filt_ff[2];
  assign fast_tick = clk_sel_ff ? rise[3] : rise[2];
  // Alignment acts on the synchronised pin in every role
  assign align_hold = ~func_lvl;
  assign align_rise = rise[4];
  generate
    for (genvar d = 0; d < NUM_DIV; d++) begin : g_div
      logic [4:0] cnt_ff;
      logic wait_ff, affected;
      assign affected = ~div_cfg_ff[d].pdown & ~div_cfg_ff[d].nosync &
                        ~div_cfg_ff[d].bypass;
      always_ff @(posedge CLK_SYS_I) begin
        if (!RESET_N_I) begin
          DIV_OUT_O[d] <= 1'b0;
          cnt_ff <= 5'h00;
          wait_ff <= 1'b0;
        end else if (div_cfg_ff[d].pdown) begin
          DIV_OUT_O[d] <= 1'b0;
        end else if (div_cfg_ff[d].bypass) begin
          DIV_OUT_O[d] <= fast_lvl;
        end else if (affected && align_hold) begin
          DIV_OUT_O[d] <= div_phase_ff[d].start_level;
          cnt_ff <= 5'h00;
          wait_ff <= 1'b0;
        end else if (affected && align_rise) begin
          cnt_ff <= {1'b0, div_phase_ff[d].phase};
          wait_ff <= 1'b1;
        end else if (fast_tick) begin
          if (cnt_ff != 5'h00) begin
            cnt_ff <= cnt_ff - 5'h01;
          end else begin
            wait_ff <= 1'b0;
            DIV_OUT_O[d] <= ~DIV_OUT_O[d];
            cnt_ff <= DIV_OUT_O[d] ? {1'b0, div_cfg_ff[d].low_cycles}
                                   : {1'b0, div_cfg_ff[d].high_cycles};
          end
        end
      end
    end
  endgenerate

  // Read channel
  logic [31:0] rd_val;
  logic rd_hit;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (S_AXI_ARADDR_I)
      PLL_CTRL_ADDR: rd_val[STAT_SEL_LSB +: 4] = stat_sel_ff;
      LOCK_CTRL_ADDR: rd_val[6:0] = {ld_dis_ff, window_ff, 3'h0, antibl_ff};
      REFMON_CTRL_ADDR: begin
        rd_val[ARM_SEL_LSB +: 2] = arm_sel_ff;
        rd_val[MON_EN_BIT] = mon_en_ff;
      end
      FUNC_CTRL_ADDR: rd_val[ROLE_LSB +: 2] = role_ff;
      CLK_SEL_ADDR: rd_val[0] = clk_sel_ff;
      STATUS_ADDR: rd_val[4:0] = {armed, POWERDOWN_O, CP_TRISTATE_O,
                                  ref_lost_ff, lock_ff};
      default: begin
        rd_hit = 1'b0;
        for (int d = 0; d < NUM_DIV; d++) begin
          if (S_AXI_ARADDR_I == DIV_CFG_ADDR + 8'(4 * d)) begin
            rd_val[10:0] = div_cfg_ff[d];
            rd_hit = 1'b1;
          end
          if (S_AXI_ARADDR_I == DIV_PHASE_ADDR + 8'(4 * d)) begin
            rd_val[4:0] = div_phase_ff[d];
            rd_hit = 1'b1;
          end
        end
      end
    endcase
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h0000_0000;
      S_AXI_RRESP_O <= 2'h0;
    end else begin
      S_AXI_ARREADY_O <= ~S_AXI_RVALID_O & ~S_AXI_ARREADY_O;
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RDATA_O <= rd_val;
        S_AXI_RRESP_O <= rd_hit ? 2'h0 : 2'h2;
      end else if (S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/clk_supervisor_props.sv
`default_nettype none
module clk_supervisor_props
  import clk_supervisor_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire logic FUNC_PIN_I,
  input wire logic POWERDOWN_O,
  input wire logic [1:0] ANTIBACKLASH_O,
  input wire logic DIST_SEL_O,
  input wire logic [NUM_DIV-1:0] DIV_OUT_O,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic [1:0] S_AXI_RRESP_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);
  property p_b_hold;
    S_AXI_BVALID_O && !S_AXI_BREADY_I |=>
      S_AXI_BVALID_O && $stable(S_AXI_BRESP_O);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bresp dropped");
  property p_r_hold;
    S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
      S_AXI_RVALID_O && $stable(S_AXI_RDATA_O);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rdata dropped");
  property p_r_err;
    S_AXI_RVALID_O && S_AXI_RRESP_O == 2'h2 |-> S_AXI_RDATA_O == 32'h0;
  endproperty
  a_r_err: assert property (p_r_err) else $error("refused read data");
  property p_pd_rise;
    $rose(POWERDOWN_O) |-> !FUNC_PIN_I || !$past(FUNC_PIN_I);
  endproperty
  a_pd_rise: assert property (p_pd_rise) else $error("power-down no pin");
  property p_pd_rel;
    FUNC_PIN_I [*6] |-> !POWERDOWN_O;
  endproperty
  a_pd_rel: assert property (p_pd_rel) else $error("power-down stuck");
  // Async clear may move the fields between two writes
  property p_dsel;
    $changed(DIST_SEL_O) |-> S_AXI_BVALID_O || $past(S_AXI_BVALID_O) ||
      !FUNC_PIN_I || !$past(FUNC_PIN_I);
  endproperty
  a_dsel: assert property (p_dsel) else $error("input select moved");
  property p_ab;
    $changed(ANTIBACKLASH_O) |-> S_AXI_BVALID_O || $past(S_AXI_BVALID_O) ||
      !FUNC_PIN_I || !$past(FUNC_PIN_I);
  endproperty
  a_ab: assert property (p_ab) else $error("antibacklash moved");
  property p_div_hold;
    !FUNC_PIN_I [*8] |-> $stable(DIV_OUT_O);
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("divider moved");
endmodule
bind clk_supervisor clk_supervisor_props props_u (.*);
`default_nettype wire

// ===== tb/pll_partner.sv
`default_nettype none
module pll_partner (
  input wire logic ref_on_i,
  input wire logic [7:0] skew_i,
  output logic ref_o,
  output logic fb_o,
  output logic vco_o,
  output logic dist_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic fb_raw = 1'b0;
  initial {ref_o, fb_o, vco_o, dist_o} = '0;
  // Edges kept off the sampling clock edges so the synchroniser sees them
  always #20 vco_o = ~vco_o;
  always #30 dist_o = ~dist_o;
  // Same grid as feedback, so a restart comes back in phase
  always begin
    #40;
    fb_raw = ~fb_raw;
    ref_o = ref_on_i & fb_raw;
  end
  always @(fb_raw) fb_o <= #(skew_i) fb_raw;
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`default_nettype none
module testbench
  import clk_supervisor_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] CODES [6] = '{SEL_LOCK_HI, SEL_LOCK_LO,
    SEL_OR_HI, SEL_OR_LO, SEL_REFERENCE_LOST_FLAG_HI, SEL_REFERENCE_LOST_FLAG_LO};
  logic clk = 1'b0, rst_n = 1'b0, func = 1'b1, analog_lock_indicator = 1'b0, ref_on = 1'b1;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [7:0] skew = 8'h00, seed = 8'h29, awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, rd_seen;
  logic ref_c, fb_c, vco_c, dist_c, st, st_oe, cp, pd, dsel;
  logic awr, wr_r, bv, arr, rv;
  logic [1:0] ab, bresp, rresp, bresp_seen, rresp_seen, v;
  logic [NUM_DIV-1:0] dv;
  int fail_count = 0, check_count = 0;
  always #5 clk = ~clk;
  pll_partner far_u (.ref_on_i(ref_on), .skew_i(skew), .ref_o(ref_c),
    .fb_o(fb_c), .vco_o(vco_c), .dist_o(dist_c));
  clk_supervisor #(.REF_LOSS_TICKS(16'h0008)) dut_u (.CLK_SYS_I(clk),
    .RESET_N_I(rst_n), .REF_CLK_I(ref_c), .FB_CLK_I(fb_c),
    .VCO_CLK_I(vco_c), .DIST_CLK_I(dist_c), .FUNC_PIN_I(func),
    .ANALOG_LOCK_I(analog_lock_indicator), .STATUS_O(st), .STATUS_OE_O(st_oe),
    .CP_TRISTATE_O(cp), .POWERDOWN_O(pd), .ANTIBACKLASH_O(ab),
    .DIST_SEL_O(dsel), .DIV_OUT_O(dv), .S_AXI_AWADDR_I(awa),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_r),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(rr));
  task automatic complete_run();
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Reference present, so the lost flag stays clear
  function automatic logic exp_pin(input logic [3:0] c, input logic lk);
    case (c)
      SEL_LOCK_HI, SEL_OR_LO: return lk;
      SEL_LOCK_LO, SEL_OR_HI: return !lk;
      SEL_REFERENCE_LOST_FLAG_LO: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (awr && !ad) begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (wr_r && !dd) begin
        dd = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (!bv);
    bresp_seen = bresp;
    br <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rd_seen = rdat;
    rresp_seen = rresp;
    rr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic lock_is(input logic e);
    tick(60);
    axi_rd(STATUS_ADDR);
    chk("lock", rd_seen[0], e);
  endtask
  task automatic pins(input logic lk);
    foreach (CODES[i]) begin
      axi_wr(PLL_CTRL_ADDR, 32'(CODES[i]) << STAT_SEL_LSB);
      tick(3);
      chk("status", st, exp_pin(CODES[i], lk));
      chk("status oe", st_oe, 1);
    end
  endtask
  initial begin
    tick(20000);
    fail_count++;
    complete_run();
  end
  initial begin
    tick(12);
    rst_n <= 1'b1;
    tick(1);
    axi_rd(CLK_SEL_ADDR);
    chk("clk sel", rd_seen, 1);
    chk("ab", ab, 0);
    axi_rd(8'hFC);
    chk("bad rd", rresp_seen, 2);
    axi_wr(STATUS_ADDR, 32'hF);
    chk("ro wr", bresp_seen, 2);
    axi_wr(CLK_SEL_ADDR, 0);
    tick(2);
    chk("dist sel", dsel, 0);
    repeat (4) begin
      seed = lfsr(seed);
      axi_wr(LOCK_CTRL_ADDR, 32'(seed[1:0]));
      tick(2);
      chk("ab", ab, seed[1:0]);
    end
    axi_wr(LOCK_CTRL_ADDR, 0);
    lock_is(1);
    pins(1);
    skew <= 8'd40;
    lock_is(0);
    pins(0);
    axi_wr(LOCK_CTRL_ADDR, 32'h1 << WINDOW_BIT);
    lock_is(0);
    skew <= 8'd0;
    lock_is(1);
    axi_wr(LOCK_CTRL_ADDR, 32'h1 << LD_DIS_BIT);
    lock_is(0);
    axi_wr(REFMON_CTRL_ADDR, 32'h64);
    ref_on <= 1'b0;
    tick(100);
    chk("cp unarmed", cp, 0);
    ref_on <= 1'b1;
    axi_wr(LOCK_CTRL_ADDR, 0);
    axi_wr(PLL_CTRL_ADDR, 32'(SEL_REFERENCE_LOST_FLAG_HI) << STAT_SEL_LSB);
    tick(300);
    ref_on <= 1'b0;
    tick(100);
    chk("cp", cp, 1);
    chk("lost pin", st, 1);
    ref_on <= 1'b1;
    tick(100);
    axi_rd(STATUS_ADDR);
    chk("lost", rd_seen[2:1], 2'h3);
    axi_wr(REFMON_CTRL_ADDR, 32'h60);
    tick(3);
    chk("cp", {cp, st}, 0);
    axi_wr(REFMON_CTRL_ADDR, 32'h64);
    tick(3);
    chk("cp", cp, 0);
    for (int i = 0; i < 2; i++) begin
      axi_wr(PLL_CTRL_ADDR, 32'(i ? SEL_ALD_NCH : SEL_ALD_PCH) << 2);
      analog_lock_indicator <= 1'b1;
      tick(6);
      chk("ald", {st_oe, st}, {1'b1, i == 0});
      analog_lock_indicator <= 1'b0;
      tick(6);
      chk("ald oe", st_oe, 0);
    end
    v = seed[1:0] | 2'h1;
    axi_wr(LOCK_CTRL_ADDR, 32'(v));
    axi_wr(FUNC_CTRL_ADDR, 32'h3 << ROLE_LSB);
    func <= 1'b0;
    tick(6);
    chk("pd", pd, 1);
    func <= 1'b1;
    tick(8);
    chk("pd kept", {pd, ab}, {1'b0, v});
    axi_wr(DIV_PHASE_ADDR, 32'h12);
    axi_wr(FUNC_CTRL_ADDR, 32'h1 << ROLE_LSB);
    func <= 1'b0;
    tick(10);
    chk("start", dv[0], 1);
    chk("align only", {pd, ab}, {1'b0, v});
    func <= 1'b1;
    tick(6);
    chk("offset", dv[0], 1);
    axi_wr(FUNC_CTRL_ADDR, 0);
    func <= 1'b0;
    tick(2);
    chk("clear", {pd, dsel, ab}, 4'h4);
    func <= 1'b1;
    tick(6);
    axi_rd(DIV_PHASE_ADDR);
    chk("defaults", rd_seen, 0);
    complete_run();
  end
endmodule
`default_nettype wire
